// ### eeprom_loader_pkg.sv
// Summary of operation
// R1: After reset, if an EEPROM is found, fetch subsystem ID and register defaults from it.
// R2: EEPROM is always addressed at seven-bit target address 1010000b.
// R3: EEPROM image must follow the byte layout exactly, every field set deliberately.
// R4: Byte 00h is the function indicator; 00h marks the socket function block.
// R5: Byte 01h is the block byte count; 20h is expected.
// R6: Bytes 02h/03h load command register 04h, functions 0/1; bits 4:3 reserved.
// R7: Byte 0Dh loads only bit 2 of system control byte 0, function 1.
// R8: Presence is a pull-up seen on the serial clock line; load starts only then.
// R9: Data is fetched by doubleword reads, started only by reset, never by software.
// R10: Device is sole bus master, clocking the serial line near 100 kHz.
// R11: Bytes go in ascending order; only mapped bits written, others keep reset values.
package eeprom_loader_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned SCL_HZ = 100_000;
    localparam int unsigned QUARTER_CYCLES = (CLK_HZ + 4 * SCL_HZ - 1) / (4 * SCL_HZ);
    localparam int unsigned SETTLE_NS = 1000;
    localparam int unsigned SETTLE_CYCLES = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [6:0] EE_DEV_ADDR = 7'h50;
    localparam logic [7:0] EE_FUNC_IND = 8'h00;
    localparam logic [7:0] EE_BYTE_CNT = 8'h01;
    localparam logic [7:0] EE_CMD_F0 = 8'h02;
    localparam logic [7:0] EE_CMD_F1 = 8'h03;
    localparam logic [7:0] EE_SUBSYS_FIRST = 8'h04;
    localparam logic [7:0] EE_LEGACY_B0 = 8'h08;
    localparam logic [7:0] EE_LEGACY_LAST = 8'h0b;
    localparam logic [7:0] EE_SYSCTL_F0 = 8'h0c;
    localparam logic [7:0] EE_SYSCTL_F1 = 8'h0d;
    localparam logic [7:0] EE_SYSCTL_B1 = 8'h0e;
    localparam logic [7:0] EE_SYSCTL_B2 = 8'h0f;
    localparam logic [7:0] EE_LAST_MAPPED = 8'h10;
    localparam logic [7:0] EE_LAST_READ = 8'h13;
    localparam logic [7:0] SOCKET_FUNC_VALUE = 8'h00;
    localparam logic [7:0] SOCKET_BYTE_COUNT = 8'h20;
    localparam logic [7:0] CFG_CMD = 8'h04;
    localparam logic [7:0] CFG_SUBSYS_BASE = 8'h40;
    localparam logic [7:0] CFG_SYSCTL_B0 = 8'h80;
    localparam logic [7:0] CFG_SYSCTL_B1 = 8'h81;
    localparam logic [15:0] CMD_MASK = 16'h0167;
    localparam logic [7:0] LEGACY_B0_MASK = 8'hfe;
    localparam logic [7:0] SYSCTL_F0_MASK = 8'h7f;
    localparam logic [7:0] SYSCTL_F1_MASK = 8'h04;

    typedef enum logic [1:0] {func_0, func_1, func_both} func_sel_type;

    typedef struct packed {
        func_sel_type func;
        logic [7:0] addr;
        logic [15:0] data;
        logic [15:0] mask;
    } cfg_write_type;

    function automatic cfg_write_type map_byte(input logic [7:0] off, input logic [7:0] b);
        cfg_write_type w;
        logic [7:0] m;
        w = '{func: func_both, addr: 8'h00, data: 16'h0000, mask: 16'h0000};
        m = 8'hff;
        if (off == EE_CMD_F0 || off == EE_CMD_F1)
        begin
            w.func = (off == EE_CMD_F0) ? func_0 : func_1;
            w.addr = CFG_CMD;
            w.data = {7'h00, b[7], 1'b0, b[6:5], 2'b00, b[2:0]};
            w.mask = CMD_MASK;
        end
        else
        begin
            if (off <= EE_LEGACY_LAST)
            begin
                w.addr = CFG_SUBSYS_BASE + (off - EE_SUBSYS_FIRST);
                if (off == EE_LEGACY_B0)
                    m = LEGACY_B0_MASK;
            end
            else if (off == EE_SYSCTL_F0 || off == EE_SYSCTL_F1)
            begin
                w.addr = CFG_SYSCTL_B0;
                w.func = (off == EE_SYSCTL_F0) ? func_0 : func_1;
                m = (off == EE_SYSCTL_F0) ? SYSCTL_F0_MASK : SYSCTL_F1_MASK;
            end
            else
                w.addr = CFG_SYSCTL_B1 + (off - EE_SYSCTL_B1);
            w.mask = {8'h00, m};
            w.data = {8'h00, (off == EE_SYSCTL_B2) ? 8'h00 : (b & m)};
        end
        return w;
    endfunction : map_byte
endpackage : eeprom_loader_pkg

// ### eeprom_loader.sv
`timescale 1ns/1ps
module eeprom_loader
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_scl_out,
    output logic o_scl_oe,
    output logic o_sda_out,
    output logic o_sda_oe,
    output eeprom_loader_pkg::cfg_write_type o_write,
    output logic o_write_valid,
    input wire logic i_write_ready,
    output logic o_present,
    output logic o_busy,
    output logic o_done,
    output logic o_error
);
    import eeprom_loader_pkg::*;

    typedef enum {st_settle, st_start, st_byte, st_emit, st_stop, st_done, st_fail} state_type;
    typedef enum {sq_dev_w, sq_word, sq_dev_r, sq_data} seq_type;

    state_type state;
    seq_type seq;
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic [8:0] div_cnt;
    logic [7:0] settle_cnt;
    logic [1:0] q;
    logic [3:0] bitn;
    logic [7:0] tx_byte;
    logic [7:0] rx_byte;
    logic [7:0] ee_addr;
    logic scl_low;
    logic sda_low;
    logic failed;
    logic present;
    cfg_write_type buf_mem [2];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and quarter-bit divider

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
        end
        else
        begin
            scl_sync <= {scl_sync[0], i_scl};
            sda_sync <= {sda_sync[0], i_sda};
        end
    end

    wire scl_s = scl_sync[1];
    wire sda_s = sda_sync[1];
    wire tick = (div_cnt == 9'(QUARTER_CYCLES - 1));

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n || tick)
            div_cnt <= 9'h000;
        else
            div_cnt <= div_cnt + 9'h001;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decoding

    wire is_rx = (seq == sq_data);
    wire last_in_dw = (ee_addr[1:0] == 2'h3);
    wire ack_bit = (bitn == 4'h8);
    wire want_sda_low = is_rx ? (ack_bit && !last_in_dw) : (!ack_bit && !tx_byte[7]);
    wire hdr_bad = (ee_addr == EE_FUNC_IND && rx_byte != SOCKET_FUNC_VALUE)
        || (ee_addr == EE_BYTE_CNT && rx_byte != SOCKET_BYTE_COUNT);
    wire mapped = (ee_addr >= EE_CMD_F0) && (ee_addr <= EE_LAST_MAPPED);
    wire buf_full = (count == 2'h2);
    wire emit_go = (state == st_emit) && (!mapped || failed || hdr_bad || !buf_full);
    wire push = emit_go && mapped && !failed && !hdr_bad;
    wire pop = o_write_valid && i_write_ready;
    wire [7:0] next_ee_addr = ee_addr + 8'h01;
    cfg_write_type mapped_word;
    assign mapped_word = map_byte(ee_addr, rx_byte);

    ////////////////////////////////////////////////////////////////////////////
    // Load sequencer: reset-only start, doubleword random reads

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            state <= st_settle;
            seq <= sq_dev_w;
            settle_cnt <= 8'(SETTLE_CYCLES);
            q <= 2'h0;
            bitn <= 4'h0;
            tx_byte <= 8'h00;
            rx_byte <= 8'h00;
            ee_addr <= 8'h00;
            scl_low <= 1'b0;
            sda_low <= 1'b0;
            failed <= 1'b0;
            present <= 1'b0;
        end
        else
        begin
            unique case (state)
                st_settle:
                begin
                    settle_cnt <= settle_cnt - 8'h01;
                    if (settle_cnt == 8'h00)
                    begin
                        present <= scl_s; // [R8]
                        state <= scl_s ? st_start : st_done; // [R8] [R1]
                        q <= 2'h0;
                    end
                end
                st_start:
                    if (tick)
                    begin
                        q <= q + 2'h1;
                        unique case (q)
                            2'h0: sda_low <= 1'b0;
                            2'h1: scl_low <= 1'b0;
                            2'h2: sda_low <= 1'b1;
                            2'h3:
                            begin
                                scl_low <= 1'b1;
                                bitn <= 4'h0;
                                state <= st_byte;
                                tx_byte <= {EE_DEV_ADDR, seq == sq_dev_r}; // [R2]
                            end
                        endcase
                    end
                st_byte:
                    if (tick)
                    begin
                        q <= q + 2'h1;
                        unique case (q)
                            2'h0: sda_low <= want_sda_low;
                            2'h1: scl_low <= 1'b0;
                            2'h2:
                            begin
                                if (!ack_bit)
                                    rx_byte <= {rx_byte[6:0], sda_s};
                                else if (!is_rx && sda_s)
                                    failed <= 1'b1;
                            end
                            2'h3:
                            begin
                                scl_low <= 1'b1;
                                tx_byte <= {tx_byte[6:0], 1'b0};
                                bitn <= bitn + 4'h1;
                                if (ack_bit)
                                begin
                                    bitn <= 4'h0;
                                    if (!is_rx && failed)
                                        state <= st_stop;
                                    else if (seq == sq_dev_w)
                                    begin
                                        seq <= sq_word;
                                        tx_byte <= ee_addr;
                                    end
                                    else if (seq == sq_word)
                                    begin
                                        seq <= sq_dev_r;
                                        state <= st_start;
                                    end
                                    else if (seq == sq_dev_r)
                                        seq <= sq_data;
                                    else
                                        state <= st_emit;
                                end
                            end
                        endcase
                    end
                st_emit:
                    if (emit_go) // [R11]
                    begin
                        if (hdr_bad)
                            failed <= 1'b1; // [R4] [R5]
                        ee_addr <= next_ee_addr; // [R11]
                        q <= 2'h0;
                        if (!last_in_dw)
                            state <= st_byte; // [R9]
                        else if (ee_addr == EE_LAST_READ || failed || hdr_bad)
                            state <= st_stop;
                        else
                        begin
                            seq <= sq_dev_w;
                            state <= st_start;
                        end
                    end
                st_stop:
                    if (tick)
                    begin
                        q <= q + 2'h1;
                        unique case (q)
                            2'h0: sda_low <= 1'b1;
                            2'h1: scl_low <= 1'b0;
                            2'h2: sda_low <= 1'b0;
                            2'h3: state <= failed ? st_fail : st_done;
                        endcase
                    end
                st_done, st_fail:
                begin
                    scl_low <= 1'b0; // [R10]
                    sda_low <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Two-entry write buffer

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
            buf_mem[0] <= '0;
            buf_mem[1] <= '0;
        end
        else
        begin
            if (push)
            begin
                buf_mem[wr_ptr] <= mapped_word; // [R6] [R7] [R11]
                wr_ptr <= !wr_ptr;
            end
            if (pop)
                rd_ptr <= !rd_ptr;
            count <= count + 2'(push) - 2'(pop);
        end
    end

    assign o_write = buf_mem[rd_ptr];
    assign o_write_valid = (count != 2'h0);
    assign o_scl_out = 1'b0;
    assign o_scl_oe = scl_low; // [R10]
    assign o_sda_out = 1'b0;
    assign o_sda_oe = sda_low;
    assign o_present = present;
    assign o_busy = (state != st_done) && (state != st_fail);
    assign o_done = (state == st_done) && (count == 2'h0);
    assign o_error = (state == st_fail);

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    dev_addr_a: assert property ((state == st_byte && seq == sq_dev_w && bitn == 4'h0) |-> tx_byte == 8'ha0) // [R2]
        else $error("wrong target address sent");
    detect_gate_a: assert property ((state == st_settle && settle_cnt == 8'h00 && !scl_s) |=> state == st_done) // [R8]
        else $error("load started without pull-up");
    scl_pace_a: assert property ($changed(scl_low) |-> $past(tick)) // [R10]
        else $error("serial clock changed off the divider");
    quarter_a: assert property (tick |=> !tick [*8]) // [R10]
        else $error("divider too fast");
    mask_only_a: assert property (o_write_valid |-> (o_write.data & ~o_write.mask) == 16'h0000) // [R11]
        else $error("unmapped bit written");
    header_fn_a: assert property ((state == st_emit && ee_addr == 8'h00 && rx_byte != 8'h00) |=> failed && !$past(push)) // [R4]
        else $error("bad indicator accepted");
    header_cnt_a: assert property ((state == st_emit && ee_addr == 8'h01 && rx_byte != 8'h20) |=> failed) // [R5]
        else $error("bad byte count accepted");
    cmd_map_a: assert property ((push && ee_addr == 8'h03) |-> mapped_word.func == func_1
        && mapped_word.mask == 16'h0167 && mapped_word.data[8] == rx_byte[7]) // [R6]
        else $error("command byte mis-mapped");
    sysctl_f1_a: assert property ((push && ee_addr == 8'h0d) |-> mapped_word.mask == 16'h0004
        && mapped_word.addr == 8'h80 && mapped_word.func == func_1) // [R7]
        else $error("system control bit mis-mapped");
    ascend_a: assert property (push |=> ee_addr == $past(ee_addr) + 8'h01) // [R11]
        else $error("offset not ascending");
    no_restart_a: assert property ((state == st_done) |=> state == st_done && !scl_low) // [R9] [R1]
        else $error("load restarted without reset");
    hold_word_a: assert property ((o_write_valid && !i_write_ready) |=> o_write_valid && $stable(o_write))
        else $error("stalled word lost");

    load_ok_c: cover property ($rose(o_done) && o_present);
    absent_c: cover property ($rose(o_done) && !o_present);
    load_fail_c: cover property ($rose(o_error));
    stall_c: cover property (buf_full && state == st_emit && mapped);
endmodule : eeprom_loader

// ### eeprom_model.sv
`timescale 1ns/1ps
module eeprom_model
(
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_oe
);
    logic [7:0] mem [0:19];
    logic [7:0] ptr = 8'h00;
    logic [7:0] sh = 8'h00;
    logic [7:0] cur = 8'h00;
    logic [3:0] cnt = 4'hf;
    logic [1:0] phase = 2'd0;
    logic rd = 1'b0;
    int reads = 0;
    initial o_sda_oe = 1'b0;
    ////////////////////////////////////////////////////////////
    always @(negedge i_sda)
        if (i_scl)
        begin
            phase = 2'd1;
            cnt = 4'hf;
            o_sda_oe = 1'b0;
        end
    always @(posedge i_sda)
        if (i_scl)
            phase = 2'd0;
    always @(posedge i_scl)
        if (phase != 2'd3 && cnt < 4'd8)
            sh = {sh[6:0], i_sda};
        else if (phase == 2'd3 && cnt == 4'd8 && i_sda)
            phase = 2'd0;
    // Slave changes SDA only on SCL falling edges and holds it through SCL high, released line floats to the pull-up
    always @(negedge i_scl)
        if (phase != 2'd0)
        begin
            if (cnt == 4'hf)
                cnt = 4'd0;
            else if (cnt < 4'd7)
            begin
                cnt = cnt + 4'd1;
                if (phase == 2'd3)
                    o_sda_oe = ~cur[3'd7 - cnt[2:0]];
            end
            else if (cnt == 4'd7)
            begin
                cnt = 4'd8;
                o_sda_oe = (phase == 2'd2) || (phase == 2'd1 && sh[7:1] == 7'h50);
                if (phase == 2'd1)
                    rd = sh[0];
                if (phase == 2'd1 && !o_sda_oe)
                    phase = 2'd0;
                if (phase == 2'd2)
                    ptr = sh;
            end
            else
            begin
                cnt = 4'd0;
                o_sda_oe = 1'b0;
                if (phase == 2'd3)
                    ptr = ptr + 8'h01;
                if (phase == 2'd1 && rd)
                    reads = reads + 1;
                if (phase == 2'd3 || (phase == 2'd1 && rd))
                begin
                    phase = 2'd3;
                    cur = mem[ptr];
                    o_sda_oe = ~cur[7];
                end
                else if (phase == 2'd1)
                    phase = 2'd2;
            end
        end
endmodule : eeprom_model

// ### tb.sv
`timescale 1ns/1ps
module tb;
    import eeprom_loader_pkg::*;
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_write_ready = 1'b0;
    logic pull_en = 1'b0;
    logic stall = 1'b1;
    logic o_scl_oe, o_sda_oe, ee_oe, o_write_valid, o_present, o_busy, o_done, o_error;
    cfg_write_type o_write;
    cfg_write_type held;
    cfg_write_type got[$];
    logic held_v = 1'b0;
    realtime rise_t[$];
    wire scl_w = pull_en & ~o_scl_oe;
    wire sda_w = ~(o_sda_oe | ee_oe);
    int err_total = 0;
    int checks_done = 0;
    logic [15:0] lfsr = 16'h0019;
    logic [15:0] rlfsr = 16'h0019;
    eeprom_loader dut_u (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_scl(scl_w), .i_sda(sda_w),
        .o_scl_out(), .o_scl_oe(o_scl_oe), .o_sda_out(), .o_sda_oe(o_sda_oe), .o_write(o_write),
        .o_write_valid(o_write_valid), .i_write_ready(i_write_ready), .o_present(o_present),
        .o_busy(o_busy), .o_done(o_done), .o_error(o_error));
    eeprom_model ee_u (.i_scl(scl_w), .i_sda(sda_w), .o_sda_oe(ee_oe));
    ////////////////////////////////////////////////////////////
    function automatic logic [15:0] step(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : step
    function automatic cfg_write_type exp_word(input logic [7:0] off, input logic [7:0] b);
        cfg_write_type w;
        w.func = func_both;
        w.mask = 16'h00ff;
        if (off == 8'h08)
            w.mask = 16'h00fe;
        if (off == 8'h0c || off == 8'h0d)
            w.func = (off == 8'h0c) ? func_0 : func_1;
        if (off == 8'h0c || off == 8'h0d)
            w.mask = (off == 8'h0c) ? 16'h007f : 16'h0004;
        w.addr = (off < 8'h0c) ? off + 8'h3c : (off < 8'h0e) ? 8'h80 : off + 8'h73;
        w.data = (off == 8'h0f) ? 16'h0000 : {8'h00, b & w.mask[7:0]};
        if (off == 8'h02 || off == 8'h03)
            w = '{func: (off == 8'h02) ? func_0 : func_1, addr: 8'h04, mask: 16'h0167,
                data: {7'h00, b[7], 1'b0, b[6:5], 2'b00, b[2:0]}};
        return w;
    endfunction : exp_word
    task automatic check(input logic [41:0] seen, input logic [41:0] exp, input string msg);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : check
    task tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic start_run(input logic pull);
        @(posedge i_clock);
        #1;
        i_rst_n = 1'b0;
        pull_en = pull;
        got.delete();
        rise_t.delete();
        repeat (3) @(posedge i_clock);
        #1 i_rst_n = 1'b1;
    endtask : start_run
    task automatic wait_end(input int bound);
        int n;
        n = 0;
        while (o_done !== 1'b1 && o_error !== 1'b1 && n < bound)
        begin
            @(posedge i_clock);
            n++;
        end
        if (n >= bound)
        begin
            err_total++;
            $display("[FAIL] %0t wait timed out", $time);
            tally_and_finish();
        end
    endtask : wait_end
    ////////////////////////////////////////////////////////////
    initial
    begin
        forever #5 i_clock = ~i_clock;
    end
    always @(posedge i_clock)
    begin
        #1;
        rlfsr = step(rlfsr);
        i_write_ready = ~stall & rlfsr[0];
    end
    always @(posedge scl_w)
        if (i_rst_n)
            rise_t.push_back($realtime);
    always @(posedge i_clock)
        if (i_rst_n)
        begin
            if (held_v)
                check(o_write, held, "word changed while stalled");
            held_v <= o_write_valid & ~i_write_ready;
            held <= o_write;
            if (o_write_valid & i_write_ready)
                got.push_back(o_write);
        end
        else
            held_v <= 1'b0;
    initial
    begin
        start_run(1'b0);
        wait_end(1000);
        check(o_done, 1'b1, "no load end without pull-up");
        check(o_present, 1'b0, "presence without pull-up");
        check(rise_t.size(), 0, "clock moved without pull-up");
        $display("test absent done");
        ee_u.mem[0] = 8'h00;
        ee_u.mem[1] = 8'h20;
        for (int i = 2; i < 20; i++)
        begin
            lfsr = step(lfsr);
            ee_u.mem[i] = lfsr[7:0];
        end
        ee_u.mem[2] = 8'hff;
        ee_u.mem[3] = 8'h18;
        ee_u.mem[15] = 8'hff;
        stall = 1'b1;
        start_run(1'b1);
        // Long enough for the second doubleword to find the buffer full
        repeat (110000) @(posedge i_clock);
        check({o_write_valid, o_scl_oe, o_busy, got.size() == 0}, 4'hf, "link not paused while full");
        stall = 1'b0;
        wait_end(400000);
        check(got.size(), 15, "word count");
        for (int i = 0; i < 15 && i < got.size(); i++)
            check(got[i], exp_word(8'(i + 2), ee_u.mem[i + 2]), "loaded word");
        check({o_done, o_error, o_present}, 3'b101, "load status");
        check(ee_u.reads, 5, "doubleword reads");
        check(rise_t.size() > 1 && rise_t[1] - rise_t[0] == 10000.0, 1'b1, "serial clock period");
        $display("test full load done");
        for (int k = 0; k < 2; k++)
        begin
            ee_u.mem[0] = k ? 8'h00 : 8'h01;
            ee_u.mem[1] = k ? 8'h1f : 8'h20;
            start_run(1'b1);
            wait_end(100000);
            check({o_error, o_busy}, 2'b10, "bad header status");
            check(got.size(), 0, "words after bad header");
            $display("test bad header %0d done", k);
        end
        tally_and_finish();
    end
endmodule : tb
